// ### core/adcstc_core.v
`timescale 1ns/100ps
`include "adcstc_regs.vh"
// Function
// R1: trigger off, scan clear: one sequence then stop, trigger ignored.
// R2: trigger off, scan set: sequences back to back, trigger ignored.
// R3: edge mode: one sequence per edge, polarity picks falling or rising.
// R4: level mode: convert continuously while trigger active at polarity.
// R5: trigger taken from analog channel 7 pin.
// R6: active edge during conversion sets trigger overrun flag.
// R7: first conversion starts within one clock of trigger; here three clocks after the pin edge, two in the synchroniser.
// R8: channel 7 results meaningless while trigger enabled.
// R9: with trigger enabled, start writes do not start conversions.
// R10: level mode retoggles during sequence do not set overrun.
// R11: level still active at sequence end restarts immediately.
// R12: digital input buffers gated per channel by enable bits.
// R13: stop mode halts conversion, leaving it resumes.
// R14: wait mode halts conversion only when wait-halt bit set.
// R15: power-up cleared aborts conversion; resets powered down.
// R16: with trigger disabled, start write starts a sequence.
// R17: software waits recovery time before writing length and timing.
// R18: converter clock is half bus clock over prescaler plus one.
// R19: writing irq enable to 0 aborts ongoing sequence.
// R20: write 1 clears complete flag; other flags clear at next start.
// R21: interrupt on sequence complete, gated by irq enable.
// R22: software clears irq enable and flag before powering down.
// R23: port bit reads pin when buffer enabled, else 1.
// R24: trigger synchronised before edge or level detection.
module adcstc_core #(
    parameter NCH = `ADCSTC_NCH,
    parameter PR_W = `ADCSTC_PR_W
) (
    // clock and reset
    input wire CLK,
    input wire NRST,
    // configuration
    input wire CONVERTER_POWER_UP,
    input wire SEQ_COMPLETE_IRQ_ENABLE,
    input wire IRQ_ENABLE_WRITE,
    input wire WAIT_HALT_BIT,
    input wire TRIGGER_ENABLE,
    input wire TRIGGER_LEVEL_SELECT,
    input wire TRIGGER_POLARITY,
    input wire SCAN_CONTINUOUS,
    input wire [PR_W-1:0] CLOCK_PRESCALER,
    input wire [3:0] SEQUENCE_LENGTH,
    input wire SEQUENCE_START_WRITE,
    input wire SEQ_COMPLETE_CLEAR_WRITE,
    // low power modes
    input wire STOP_MODE,
    input wire WAIT_MODE,
    // pins
    input wire [NCH-1:0] ANALOG_PIN,
    input wire [NCH-1:0] CHANNEL_INPUT_BUFFER_ENABLE,
    // analog machine
    input wire CONVERSION_DONE,
    // status and outputs
    output reg [NCH-1:0] ANALOG_PORT_DATA,
    output reg CONVERTER_CLOCK,
    output reg CONVERTING,
    output reg CONVERSION_START,
    output reg [3:0] CONVERSION_INDEX,
    output reg CHANNEL7_RESULT_VALID,
    output reg SEQ_COMPLETE_FLAG,
    output reg TRIGGER_OVERRUN_FLAG,
    output reg IRQ
);
    reg trig_s1_reg;
    reg trig_s2_reg;
    reg trig_prev_reg;
    reg [1:0] state_reg;
    reg [PR_W-1:0] div_reg;
    reg [7:0] conv_cnt_reg;
    reg [3:0] seq_cnt_reg;
    // a done strobe that lands while halted, held until the halt ends
    reg done_pend_reg;
    wire trig_act;
    wire edge_hit;
    wire halted;
    wire abort;
    wire start_req;
    wire seq_end;
    wire conv_end;
    wire tick;
    localparam [NCH-1:0] PORT_RST = `ADCSTC_PORT_RST;
    genvar gi;

    // start condition: trigger path when enabled, start write otherwise
    function sel_start;
        input te;
        input le;
        input act;
        input hit;
        input wr;
        begin
            if (te) begin
                sel_start = le ? act : hit;
            end else begin
                sel_start = wr;
            end
        end
    endfunction

    // whether a finished sequence is followed straight by the next one
    function keep_running;
        input te;
        input le;
        input act;
        input scan;
        begin
            if (te) begin
                keep_running = le & act;
            end else begin
                keep_running = scan;
            end
        end
    endfunction

    // active level after polarity
    assign trig_act = TRIGGER_POLARITY ? trig_s2_reg : ~trig_s2_reg; // R3 R4
    assign edge_hit = trig_act & ~trig_prev_reg; // R3
    assign halted = STOP_MODE | (WAIT_MODE & WAIT_HALT_BIT); // R13 R14
    assign abort = ~CONVERTER_POWER_UP | (IRQ_ENABLE_WRITE & ~SEQ_COMPLETE_IRQ_ENABLE); // R15 R19
    assign start_req = sel_start(TRIGGER_ENABLE, TRIGGER_LEVEL_SELECT, trig_act, edge_hit, // R3 R4 R9
        SEQUENCE_START_WRITE); // R16
    assign tick = (div_reg == {PR_W{1'b0}}) & ~halted;
    // internal conversion time model, or done strobe from analog machine; nothing ends while halted
    assign conv_end = ~halted & (CONVERSION_DONE | done_pend_reg // R13 R14
        | (tick & CONVERTER_CLOCK & (conv_cnt_reg == `ADCSTC_CONV_DEF)));
    assign seq_end = conv_end & (seq_cnt_reg + 4'h1 >= SEQUENCE_LENGTH);

    // prescaler: toggle every prescaler+1 bus clocks gives half bus over (pr+1)
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            div_reg <= {PR_W{1'b0}};
            CONVERTER_CLOCK <= 1'b0;
        end else if (!CONVERTER_POWER_UP) begin
            div_reg <= {PR_W{1'b0}};
            CONVERTER_CLOCK <= 1'b0;
        end else if (!halted) begin
            if (div_reg == {PR_W{1'b0}}) begin
                div_reg <= CLOCK_PRESCALER; // R18
                CONVERTER_CLOCK <= ~CONVERTER_CLOCK;
            end else begin
                div_reg <= div_reg - {{(PR_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // trigger on pin of channel 7, two-stage synchroniser
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            // seen as active so that no false edge follows reset with polarity clear; with polarity set a high pin still gives one
            trig_prev_reg <= 1'b1;
        end else begin
            trig_s1_reg <= ANALOG_PIN[`ADCSTC_TRIG_CH]; // R5 R24
            trig_s2_reg <= trig_s1_reg; // R24
            trig_prev_reg <= trig_act;
        end
    end

    // keeps a done strobe from the analog machine that arrives during a halt
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            done_pend_reg <= 1'b0;
        end else if (abort || (state_reg != `ADCSTC_ST_CONV)) begin
            done_pend_reg <= 1'b0;
        end else if (halted && CONVERSION_DONE) begin
            done_pend_reg <= 1'b1; // R13 R14
        end else if (!halted) begin
            done_pend_reg <= 1'b0;
        end
    end

    // sequencer
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= `ADCSTC_ST_IDLE;
            conv_cnt_reg <= 8'h00;
            seq_cnt_reg <= 4'h0;
            CONVERTING <= 1'b0;
            CONVERSION_START <= 1'b0;
            CONVERSION_INDEX <= 4'h0;
            SEQ_COMPLETE_FLAG <= 1'b0;
            TRIGGER_OVERRUN_FLAG <= 1'b0;
        end else begin
            CONVERSION_START <= 1'b0;
            if (SEQ_COMPLETE_CLEAR_WRITE) begin
                SEQ_COMPLETE_FLAG <= 1'b0; // R20
            end
            if (abort) begin
                state_reg <= `ADCSTC_ST_IDLE; // R15 R19
                CONVERTING <= 1'b0;
            end else begin
                case (state_reg)
                    `ADCSTC_ST_IDLE: begin
                        if (start_req && !halted) begin
                            state_reg <= `ADCSTC_ST_CONV; // R7
                            CONVERTING <= 1'b1;
                            CONVERSION_START <= 1'b1;
                            seq_cnt_reg <= 4'h0;
                            conv_cnt_reg <= 8'h00;
                            CONVERSION_INDEX <= 4'h0;
                            TRIGGER_OVERRUN_FLAG <= 1'b0; // R20
                        end
                    end
                    `ADCSTC_ST_CONV: begin
                        if (TRIGGER_ENABLE && !TRIGGER_LEVEL_SELECT && edge_hit) begin
                            TRIGGER_OVERRUN_FLAG <= 1'b1; // R6 R10
                        end
                        if (tick && CONVERTER_CLOCK) begin
                            conv_cnt_reg <= conv_cnt_reg + 8'h01; // R13 R14
                        end
                        if (conv_end) begin
                            conv_cnt_reg <= 8'h00;
                            if (seq_end) begin
                                SEQ_COMPLETE_FLAG <= 1'b1; // R21
                                seq_cnt_reg <= 4'h0;
                                CONVERSION_INDEX <= 4'h0;
                                if (keep_running(TRIGGER_ENABLE, TRIGGER_LEVEL_SELECT, trig_act, SCAN_CONTINUOUS)) begin
                                    CONVERSION_START <= 1'b1; // R2 R4 R11
                                end else begin
                                    state_reg <= `ADCSTC_ST_IDLE; // R1 R3
                                    CONVERTING <= 1'b0;
                                end
                            end else begin
                                seq_cnt_reg <= seq_cnt_reg + 4'h1;
                                CONVERSION_INDEX <= seq_cnt_reg + 4'h1;
                                CONVERSION_START <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_reg <= `ADCSTC_ST_IDLE;
                        CONVERTING <= 1'b0;
                    end
                endcase
            end
        end
    end

    // interrupt request follows the flag, gated by its enable
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= SEQ_COMPLETE_FLAG & SEQ_COMPLETE_IRQ_ENABLE; // R21
        end
    end

    // trigger channel results carry no meaning while the trigger is in use
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CHANNEL7_RESULT_VALID <= 1'b0;
        end else begin
            CHANNEL7_RESULT_VALID <= ~TRIGGER_ENABLE; // R8
        end
    end

    // digital port: pin level through an enabled buffer, else reads high
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_port
            always @(posedge CLK or negedge NRST) begin
                if (!NRST) begin
                    ANALOG_PORT_DATA[gi] <= PORT_RST[gi];
                end else if (CHANNEL_INPUT_BUFFER_ENABLE[gi]) begin
                    ANALOG_PORT_DATA[gi] <= ANALOG_PIN[gi]; // R12 R23
                end else begin
                    // buffer off: no current drawn, bit reads high
                    ANALOG_PORT_DATA[gi] <= 1'b1; // R12 R23
                end
            end
        end
    endgenerate
endmodule // adcstc_core

// ### shared/adcstc_regs.vh
`ifndef ADCSTC_REGS_VH
`define ADCSTC_REGS_VH
// channel count and trigger channel
`define ADCSTC_NCH 8
`define ADCSTC_TRIG_CH 7
// prescaler width
`define ADCSTC_PR_W 5
// default sequence length
`define ADCSTC_SEQ_DEF 4'h4
// conversion length in converter clocks
`define ADCSTC_CONV_DEF 8'h0E
// reset values
`define ADCSTC_PORT_RST 8'hFF
`define ADCSTC_PWR_RST 1'b0
// sequencer states
`define ADCSTC_ST_IDLE 2'h0
`define ADCSTC_ST_CONV 2'h1
`endif

// ### tb/adcstc_partner.sv
`timescale 1ns/100ps
module adcstc_partner (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // conversion handshake
    input logic start,
    output logic done
);
    int cnt_reg;
    // each conversion ends after a random delay, prompt or slow
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 0;
            done <= 1'b0;
        end else begin
            done <= cnt_reg == 1;
            cnt_reg <= start ? $urandom_range(1, 6) : (cnt_reg ? cnt_reg - 1 : 0);
        end
    end
endmodule // adcstc_partner

// ### tb/adcstc_properties.sv
`timescale 1ns/100ps
module adcstc_properties #(parameter NCH = 8) (
    // controls
    input logic CLK, NRST, CONVERTER_POWER_UP, SEQ_COMPLETE_IRQ_ENABLE, IRQ_ENABLE_WRITE, SEQUENCE_START_WRITE,
    input logic TRIGGER_ENABLE, TRIGGER_LEVEL_SELECT, TRIGGER_POLARITY, STOP_MODE, WAIT_MODE,
    // pins
    input logic [NCH-1:0] ANALOG_PIN, CHANNEL_INPUT_BUFFER_ENABLE, ANALOG_PORT_DATA,
    // status
    input logic CONVERTING, CONVERSION_START, CHANNEL7_RESULT_VALID, SEQ_COMPLETE_FLAG, TRIGGER_OVERRUN_FLAG, IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    chk_start_write: assert property (SEQUENCE_START_WRITE && !TRIGGER_ENABLE && CONVERTER_POWER_UP
        && !CONVERTING && !STOP_MODE && !WAIT_MODE && !(IRQ_ENABLE_WRITE && !SEQ_COMPLETE_IRQ_ENABLE)
        |=> CONVERTING && CONVERSION_START) else $error("start lost");
    chk_halt_freeze: assert property (STOP_MODE |=> !CONVERSION_START) else $error("halt");
    chk_power_abort: assert property (!CONVERTER_POWER_UP |=> !CONVERTING) else $error("no abort");
    chk_irq_abort: assert property (IRQ_ENABLE_WRITE && !SEQ_COMPLETE_IRQ_ENABLE |=> !CONVERTING)
        else $error("no abort");
    chk_irq_raise: assert property ($rose(SEQ_COMPLETE_FLAG) && SEQ_COMPLETE_IRQ_ENABLE |=> IRQ)
        else $error("no irq");
    chk_port_mirror: assert property ($past(NRST) |-> ANALOG_PORT_DATA ==
        ($past(ANALOG_PIN) | ~$past(CHANNEL_INPUT_BUFFER_ENABLE))) else $error("port data");
    chk_edge_launch: assert property (TRIGGER_ENABLE && !TRIGGER_LEVEL_SELECT && !CONVERTING
        && CONVERTER_POWER_UP && !STOP_MODE && !WAIT_MODE
        && (TRIGGER_POLARITY ? $rose(ANALOG_PIN[NCH-1]) : $fell(ANALOG_PIN[NCH-1])) |-> ##[1:5] CONVERTING)
        else $error("edge lost");
    chk_level_overrun: assert property ($rose(TRIGGER_OVERRUN_FLAG) |-> !TRIGGER_LEVEL_SELECT)
        else $error("overrun");
    chk_ch7_valid: assert property ($past(NRST) |-> CHANNEL7_RESULT_VALID == !$past(TRIGGER_ENABLE))
        else $error("ch7 valid");
    cover property ($rose(IRQ));
    cover property ($rose(TRIGGER_OVERRUN_FLAG));
    cover property (CONVERSION_START && TRIGGER_LEVEL_SELECT);
endmodule // adcstc_properties
bind adcstc_core adcstc_properties #(.NCH(NCH)) props (.*);

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
    logic CLK = 0, NRST = 0, CONVERTER_POWER_UP = 0, SEQ_COMPLETE_IRQ_ENABLE = 1, IRQ_ENABLE_WRITE = 0;
    logic WAIT_HALT_BIT = 0, TRIGGER_ENABLE = 0, TRIGGER_LEVEL_SELECT = 0, TRIGGER_POLARITY = 0;
    logic SCAN_CONTINUOUS = 0, SEQUENCE_START_WRITE = 0, SEQ_COMPLETE_CLEAR_WRITE = 0, STOP_MODE = 0, WAIT_MODE = 0;
    logic [4:0] CLOCK_PRESCALER = 0;
    logic [3:0] SEQUENCE_LENGTH = 0, CONVERSION_INDEX;
    logic [7:0] ANALOG_PIN = 0, CHANNEL_INPUT_BUFFER_ENABLE = 0, ANALOG_PORT_DATA;
    logic CONVERSION_DONE, CONVERTER_CLOCK, CONVERTING, CONVERSION_START, CHANNEL7_RESULT_VALID;
    logic SEQ_COMPLETE_FLAG, TRIGGER_OVERRUN_FLAG, IRQ;
    int fails = 0, total_checks = 0, n;
    logic cc;
    always #12.5 CLK = ~CLK;
    adcstc_core dut (.*);
    adcstc_partner machine (.clk(CLK), .rst_n(NRST), .start(CONVERSION_START), .done(CONVERSION_DONE));
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge CLK);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    // counts starts over k cycles, or until the flag rises when k is 0
    task automatic count(int k, output int c);
        c = 0;
        for (int i = 0; i < (k ? k : 600) && !(k == 0 && SEQ_COMPLETE_FLAG); i++) begin
            if (k == 0 && CONVERSION_START && !TRIGGER_ENABLE) chk("index", 8'(c), 8'(CONVERSION_INDEX));
            c += CONVERSION_START;
            cyc(1);
        end
        if (k == 0 && SEQ_COMPLETE_FLAG !== 1'b1) begin
            fails++;
            final_report();
        end
    endtask
    function automatic logic [7:0] exp_len(logic [3:0] l);
        return (l == 4'h0) ? 8'h01 : {4'h0, l};
    endfunction
    task automatic final_report();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        n = $urandom(76);
        CLOCK_PRESCALER = 5'($urandom_range(0, 31));
        cyc(6);
        chk("port", 8'hFF, ANALOG_PORT_DATA);
        NRST = 1;
        pulse(SEQUENCE_START_WRITE);
        chk("pd", 0, CONVERTING);
        CONVERTER_POWER_UP = 1;
        cyc(8);
        cc = CONVERTER_CLOCK;
        for (n = 0; n < 70 && CONVERTER_CLOCK === cc; n++) cyc(1);
        cc = CONVERTER_CLOCK;
        for (n = 0; n < 70 && CONVERTER_CLOCK === cc; n++) cyc(1);
        chk("cclk", 8'(CLOCK_PRESCALER) + 8'h01, 8'(n));
        for (int k = 0; k < 4; k++) begin
            ANALOG_PIN = 8'($urandom);
            CHANNEL_INPUT_BUFFER_ENABLE = 8'($urandom);
            SEQUENCE_LENGTH = k ? 4'($urandom_range(1, 15)) : 4'h0;
            pulse(SEQUENCE_START_WRITE);
            count(0, n);
            chk("len", exp_len(SEQUENCE_LENGTH), 8'(n));
            cyc(2);
            chk("one", 0, CONVERTING);
            chk("irq", 1, IRQ);
            pulse(SEQ_COMPLETE_CLEAR_WRITE);
            chk("clr", 0, SEQ_COMPLETE_FLAG);
        end
        SCAN_CONTINUOUS = 1;
        pulse(SEQUENCE_START_WRITE);
        count(0, n);
        cyc(1);
        chk("scan", 1, CONVERTING);
        for (int m = 0; m < 3; m++) begin
            {STOP_MODE, WAIT_MODE, WAIT_HALT_BIT} = (m == 0) ? 3'h4 : ((m == 1) ? 3'h3 : 3'h2);
            cyc(3);
            count(40, n);
            chk("halt", 8'(m == 2), 8'(n != 0));
            {STOP_MODE, WAIT_MODE, WAIT_HALT_BIT} = 3'h0;
            count(40, n);
            chk("resume", 1, n != 0);
        end
        SEQ_COMPLETE_IRQ_ENABLE = 0;
        pulse(IRQ_ENABLE_WRITE);
        chk("abort", 0, CONVERTING);
        SCAN_CONTINUOUS = 0;
        SEQUENCE_LENGTH = 4'hF;
        pulse(SEQUENCE_START_WRITE);
        pulse(SEQ_COMPLETE_CLEAR_WRITE);
        cyc(1);
        CONVERTER_POWER_UP = 0;
        cyc(1);
        chk("off", 0, CONVERTING);
        SEQ_COMPLETE_IRQ_ENABLE = 1;
        CONVERTER_POWER_UP = 1;
        pulse(SEQ_COMPLETE_CLEAR_WRITE);
        for (int p = 0; p < 4; p++) begin
            TRIGGER_ENABLE = 0;
            ANALOG_PIN[7] = !p[0];
            cyc(3);
            {TRIGGER_ENABLE, TRIGGER_LEVEL_SELECT, TRIGGER_POLARITY} = {1'b1, p[1], p[0]};
            cyc(8);
            pulse(SEQUENCE_START_WRITE);
            cyc(3);
            chk("trg_only", 0, CONVERTING);
            ANALOG_PIN[7] = p[0];
            cyc(6);
            chk("launch", 1, CONVERTING);
            chk("ovr_clr", 0, TRIGGER_OVERRUN_FLAG);
            ANALOG_PIN[7] = !p[0];
            cyc(4);
            ANALOG_PIN[7] = p[0];
            count(0, n);
            chk("ovr", !p[1], TRIGGER_OVERRUN_FLAG);
            cyc(6);
            chk("after", p[1], CONVERTING);
            ANALOG_PIN[7] = !p[0];
            for (int i = 0; i < 600 && CONVERTING; i++) cyc(1);
            chk("idle", 0, CONVERTING);
            pulse(SEQ_COMPLETE_CLEAR_WRITE);
        end
        final_report();
    end
endmodule // tb
